// File: shared/sops_params.svh
// constants of the status output pin select block
`ifndef SOPS_PARAMS_SVH
`define SOPS_PARAMS_SVH

// register byte addresses
`define SOPS_ADDR_CFG_A      8'h00
`define SOPS_ADDR_CFG_B      8'h04
`define SOPS_ADDR_CFG_C      8'h08
`define SOPS_ADDR_STATUS     8'h0c
`define SOPS_ADDR_IRQ_STAT   8'h10
`define SOPS_ADDR_IRQ_MASK   8'h14
`define SOPS_ADDR_MSB        7
`define SOPS_ADDR_LSB        2

// config register field layout
`define SOPS_SEL_MSB         5
`define SOPS_POL_BIT         6
`define SOPS_TEMP_BIT        7

// reset values: a = divided clock, b = high impedance, c = rx threshold
`define SOPS_RST_CFG_A       8'h3f
`define SOPS_RST_CFG_B       8'h2e
`define SOPS_RST_CFG_C       8'h00

// select codes
`define SOPS_SEL_RX_THR      6'h00
`define SOPS_SEL_RX_PKT      6'h01
`define SOPS_SEL_TX_THR      6'h02
`define SOPS_SEL_TX_FULL     6'h03
`define SOPS_SEL_RX_OVF      6'h04
`define SOPS_SEL_TX_UNF      6'h05
`define SOPS_SEL_SYNC        6'h06
`define SOPS_SEL_CRC_OK      6'h07
`define SOPS_SEL_HIZ         6'h2e
`define SOPS_SEL_CLK_DIV     6'h3f
`define SOPS_SEL_SLEEP_LIM   6'h20
`define SOPS_TEMP_VALUE      8'h80

// divide by 192: toggle every 96 clock edges
`define SOPS_CLK_DIV         192
`define SOPS_HALF_DIV        7'd95

// axi response codes
`define SOPS_RESP_OKAY       2'b00
`define SOPS_RESP_SLVERR     2'b10

`endif

// File: shared/sops_pkg.sv
// types of the status output pin select block
package sops_pkg;

  typedef struct packed {
    logic       temp_en;
    logic       polarity;
    logic [5:0] select;
  } sops_cfg_s;

  // internal radio conditions, all active high
  typedef struct packed {
    logic rx_thr;
    logic rx_empty;
    logic rx_eop;
    logic rx_overflow;
    logic rx_flush;
    logic tx_thr;
    logic tx_full;
    logic tx_underflow;
    logic tx_flush;
    logic sync_event;
    logic pkt_end;
    logic addr_fail;
    logic crc_ok;
    logic rx_first_read;
  } sops_evt_s;

  typedef struct packed {
    logic [2:0] value;
    logic [2:0] enable;
  } sops_pins_s;

endpackage

// File: verilog/sops_status_pins.sv
// status output pin select with axi4-lite registers
//
// How it works
// RULE1 - three outputs, each with 6-bit select
// RULE2 - output b valid only while select high
// RULE3 - output b resets to high impedance
// RULE4 - output a resets to clock divided 192
// RULE5 - writing 0x80 to config a enables sensor
// RULE6 - sleep below 0x20 forces polarity levels; output b is forced to the inverted polarity level
// RULE7 - forced levels held until chip ready low
// RULE8 - codes 0x20 and up work in sleep
// RULE9 - code 0x2e is high impedance always; output b is still driven with serial_data_out while serial_select_n is low
// RULE10 - code 0 follows rx threshold level
// RULE11 - code 1 rx threshold/eop until empty
// RULE12 - code 2 follows tx threshold level
// RULE13 - code 3 tx full until below threshold
// RULE14 - code 4 rx overflow until flush
// RULE15 - code 5 tx underflow until flush
// RULE16 - code 6 sync until end or error
// RULE17 - code 7 crc ok until first read
// RULE18 - polarity bit inverts the selected signal
// RULE19 - select changes act without reset
`timescale 1ns/1ps
`default_nettype none
`include "sops_params.svh"

module sops_status_pins
  import sops_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire sops_evt_s   radio_evt,
  input  wire logic        sleep_state,
  input  wire logic        chip_ready_n,
  input  wire logic        serial_select_n,
  input  wire logic        serial_data_out,
  output var  logic        status_out_a,
  output var  logic        status_out_a_oe,
  output var  logic        status_out_b,
  output var  logic        status_out_b_oe,
  output var  logic        status_out_c,
  output var  logic        status_out_c_oe,
  output var  logic        temp_sensor_en,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronise pin inputs

  logic [1:0] sel_n_sync;
  logic [1:0] sleep_sync;
  logic [1:0] rdy_n_sync;
  logic       serial_select_n_s;
  logic       sleep_s;
  logic       chip_ready_n_s;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sel_n_sync <= 2'h3;
      sleep_sync <= 2'h0;
      rdy_n_sync <= 2'h0;
    end
    else
    begin
      sel_n_sync <= {sel_n_sync[0], serial_select_n};
      sleep_sync <= {sleep_sync[0], sleep_state};
      rdy_n_sync <= {rdy_n_sync[0], chip_ready_n};
    end
  end
  assign serial_select_n_s = sel_n_sync[1];
  assign sleep_s           = sleep_sync[1];
  assign chip_ready_n_s    = rdy_n_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  sops_cfg_s  cfg [3];
  logic [5:0] irq_stat;
  logic [5:0] irq_mask;
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_go;
  logic       wr_ok;
  logic [2:0] status_vec;
  logic [5:0] evt_vec;
  logic [31:0] next_rdata;
  logic       next_rerr;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = aw_addr[1:0] == 2'h0 && aw_addr[`SOPS_ADDR_MSB:`SOPS_ADDR_LSB] <= 6'h05;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SOPS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SOPS_RESP_OKAY : `SOPS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end
  // configuration registers; updates reach the pins two clocks later, without reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg[0]   <= `SOPS_RST_CFG_A; // RULE4
      cfg[1]   <= `SOPS_RST_CFG_B; // RULE3
      cfg[2]   <= `SOPS_RST_CFG_C;
      irq_mask <= 6'h00;
    end
    else if (wr_go && w_strb[0])
    begin
      unique case (aw_addr)
        `SOPS_ADDR_CFG_A:    cfg[0]   <= w_data[7:0]; // RULE19
        `SOPS_ADDR_CFG_B:    cfg[1]   <= w_data[7:0]; // RULE19
        `SOPS_ADDR_CFG_C:    cfg[2]   <= w_data[7:0]; // RULE19
        `SOPS_ADDR_IRQ_MASK: irq_mask <= w_data[5:0];
        default:             ;
      endcase
    end
  end
  // sticky events: set wins over write-one-to-clear
  assign evt_vec = {radio_evt.crc_ok, radio_evt.sync_event, radio_evt.tx_underflow,
                    radio_evt.rx_overflow, radio_evt.tx_full, radio_evt.rx_eop};
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_stat <= 6'h00;
    else if (wr_go && w_strb[0] && aw_addr == `SOPS_ADDR_IRQ_STAT)
      irq_stat <= (irq_stat & ~w_data[5:0]) | evt_vec;
    else
      irq_stat <= irq_stat | evt_vec;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end
  always_comb
  begin
    next_rdata = 32'h0;
    next_rerr  = 1'b0;
    unique case (s_axi_araddr)
      `SOPS_ADDR_CFG_A:    next_rdata[7:0] = cfg[0];
      `SOPS_ADDR_CFG_B:    next_rdata[7:0] = cfg[1];
      `SOPS_ADDR_CFG_C:    next_rdata[7:0] = cfg[2];
      `SOPS_ADDR_STATUS:   next_rdata[2:0] = status_vec;
      `SOPS_ADDR_IRQ_STAT: next_rdata[5:0] = irq_stat;
      `SOPS_ADDR_IRQ_MASK: next_rdata[5:0] = irq_mask;
      default:             next_rerr = 1'b1;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `SOPS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rerr ? `SOPS_RESP_SLVERR : `SOPS_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= !s_axi_arready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal conditions

  logic [6:0] div_cnt;
  logic       div_clk;
  logic       rx_pkt;
  logic       tx_full_hold;
  logic       rx_ovf_hold;
  logic       tx_unf_hold;
  logic       sync_hold;
  logic       crc_hold;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_cnt <= 7'd0;
      div_clk <= 1'b0;
    end
    else if (div_cnt == `SOPS_HALF_DIV)
    begin
      div_cnt <= 7'd0;
      div_clk <= !div_clk; // RULE4
    end
    else
      div_cnt <= div_cnt + 7'd1;
  end
  // sticky conditions: set wins over clear, except sync_hold where clear wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_pkt       <= 1'b0;
      tx_full_hold <= 1'b0;
      rx_ovf_hold  <= 1'b0;
      tx_unf_hold  <= 1'b0;
      sync_hold    <= 1'b0;
      crc_hold     <= 1'b0;
    end
    else
    begin
      if (radio_evt.rx_thr || radio_evt.rx_eop)
        rx_pkt <= 1'b1; // RULE11
      else if (radio_evt.rx_empty)
        rx_pkt <= 1'b0; // RULE11
      if (radio_evt.tx_full)
        tx_full_hold <= 1'b1; // RULE13
      else if (!radio_evt.tx_thr)
        tx_full_hold <= 1'b0; // RULE13
      if (radio_evt.rx_overflow)
        rx_ovf_hold <= 1'b1; // RULE14
      else if (radio_evt.rx_flush)
        rx_ovf_hold <= 1'b0; // RULE14
      if (radio_evt.tx_underflow)
        tx_unf_hold <= 1'b1; // RULE15
      else if (radio_evt.tx_flush)
        tx_unf_hold <= 1'b0; // RULE15
      if (radio_evt.pkt_end || radio_evt.addr_fail || radio_evt.rx_overflow || radio_evt.tx_underflow)
        sync_hold <= 1'b0; // RULE16
      else if (radio_evt.sync_event)
        sync_hold <= 1'b1; // RULE16
      if (radio_evt.crc_ok)
        crc_hold <= 1'b1; // RULE17
      else if (radio_evt.rx_first_read)
        crc_hold <= 1'b0; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin selection

  logic [2:0] pin_val;
  logic [2:0] pin_oe;
  logic       sleep_force;
  // sleep forcing lasts until chip ready goes low
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sleep_force <= 1'b0;
    else if (sleep_s)
      sleep_force <= 1'b1; // RULE6
    else if (!chip_ready_n_s)
      sleep_force <= 1'b0; // RULE7
  end
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      logic sig;
      logic forced;
      always_comb
      begin
        unique case (cfg[gi].select) // RULE1
          `SOPS_SEL_RX_THR:  sig = radio_evt.rx_thr; // RULE10
          `SOPS_SEL_RX_PKT:  sig = rx_pkt;
          `SOPS_SEL_TX_THR:  sig = radio_evt.tx_thr; // RULE12
          `SOPS_SEL_TX_FULL: sig = tx_full_hold;
          `SOPS_SEL_RX_OVF:  sig = rx_ovf_hold;
          `SOPS_SEL_TX_UNF:  sig = tx_unf_hold;
          `SOPS_SEL_SYNC:    sig = sync_hold;
          `SOPS_SEL_CRC_OK:  sig = crc_hold;
          `SOPS_SEL_CLK_DIV: sig = div_clk;
          default:           sig = 1'b0;
        endcase
      end
      assign forced = sleep_force && (cfg[gi].select < `SOPS_SEL_SLEEP_LIM); // RULE6 RULE8

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          pin_val[gi] <= 1'b0;
          pin_oe[gi]  <= 1'b0;
        end
        else
        begin
          if (forced)
            pin_val[gi] <= (gi == 1) ? !cfg[gi].polarity : cfg[gi].polarity; // RULE6
          else
            pin_val[gi] <= sig ^ cfg[gi].polarity; // RULE18
          pin_oe[gi] <= (cfg[gi].select != `SOPS_SEL_HIZ) && !(gi == 0 && cfg[gi].temp_en); // RULE9
        end
      end
    end
  endgenerate
  assign status_vec = pin_val;
  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_out_a    <= 1'b0;
      status_out_a_oe <= 1'b0;
      status_out_b    <= 1'b0;
      status_out_b_oe <= 1'b0;
      status_out_c    <= 1'b0;
      status_out_c_oe <= 1'b0;
      temp_sensor_en  <= 1'b0;
    end
    else
    begin
      status_out_a    <= pin_val[0];
      status_out_a_oe <= pin_oe[0];
      status_out_c    <= pin_val[2];
      status_out_c_oe <= pin_oe[2];
      temp_sensor_en  <= cfg[0] == `SOPS_TEMP_VALUE && !pin_oe[0]; // RULE5
      if (!serial_select_n_s)
      begin
        status_out_b    <= serial_data_out; // RULE2
        status_out_b_oe <= 1'b1;
      end
      else
      begin
        status_out_b    <= pin_val[1]; // RULE2
        status_out_b_oe <= pin_oe[1];
      end
    end
  end

endmodule // sops_status_pins

`default_nettype wire

// File: testbench/sops_status_pins_monitor.sv
// port level checks of the status pin select block
`timescale 1ns/1ps
`default_nettype none
module sops_status_pins_monitor
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        serial_select_n,
  input wire logic        status_out_a_oe,
  input wire logic        status_out_b_oe,
  input wire logic        temp_sensor_en,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_temp_nodrive: assert property (temp_sensor_en |-> !status_out_a_oe)
    else $error("pin a driven with sensor on");
  a_serial_share: assert property ((!serial_select_n) [*6] |-> status_out_b_oe)
    else $error("pin b not driven while selected");
  a_rst_quiet: assert property ($past(sys_rst) |-> !status_out_a_oe && !status_out_b_oe && !irq)
    else $error("outputs active after reset");
  a_b_hiz_rst: assert property ($fell(sys_rst) |-> !status_out_b_oe [*2])
    else $error("pin b driven after reset");
  c_temp: cover property (temp_sensor_en);
  c_share: cover property (!serial_select_n && status_out_b_oe);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // sops_status_pins_monitor

bind sops_status_pins sops_status_pins_monitor u_sops_status_pins_monitor (.clk, .sys_rst, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .serial_select_n,
  .status_out_a_oe, .status_out_b_oe, .temp_sensor_en, .irq);
`default_nettype wire

// File: testbench/sops_host_model.sv
// host side view of the three status pins
`timescale 1ns/1ps
`default_nettype none
module sops_host_model
  import sops_pkg::*;
(
  input  wire logic       clk,
  input  wire sops_pins_s pins,
  output var  logic [2:0] lvl
);
  logic [2:0] last = 3'h0;
  // a released pin alternates so a stale level never passes
  always_comb lvl = (pins.value & pins.enable) | (~last & ~pins.enable);
  always_ff @(posedge clk) last <= lvl;
endmodule // sops_host_model
`default_nettype wire

// File: testbench/sops_status_pins_tb.sv
// self-checking bench of the status pin select block
`timescale 1ns/1ps
`default_nettype none
`include "sops_params.svh"
module sops_status_pins_tb
  import sops_pkg::*;
;
  logic        clk = 0, sys_rst = 1;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic        aw_r, w_r, b_v, ar_r, r_v, temp_sensor_en, irq;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_d;
  sops_evt_s   evt = '0;
  logic        sleep_state = 0, chip_ready_n = 0, serial_select_n = 1, serial_data_out = 0;
  wire sops_pins_s pins;
  logic [2:0]  lvl;
  int          error_cnt = 0, num_checks = 0, i, n;
  logic        p;
  // set, hold and clear event masks for select codes 0 to 7
  logic [13:0] tbl [8][3] = '{'{14'h2000, 14'h2000, 14'h0}, '{14'h0800, 14'h0, 14'h1000},
    '{14'h0100, 14'h0100, 14'h0}, '{14'h0180, 14'h0100, 14'h0}, '{14'h0400, 14'h0, 14'h0200},
    '{14'h0040, 14'h0, 14'h0020}, '{14'h0010, 14'h0, 14'h0008}, '{14'h0002, 14'h0, 14'h0001}};

  always #12.5 clk = ~clk;

  sops_status_pins u_sops_status_pins (.clk, .sys_rst, .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .radio_evt(evt), .sleep_state, .chip_ready_n, .serial_select_n, .serial_data_out,
    .status_out_a(pins.value[0]), .status_out_a_oe(pins.enable[0]), .status_out_b(pins.value[1]),
    .status_out_b_oe(pins.enable[1]), .status_out_c(pins.value[2]), .status_out_c_oe(pins.enable[2]),
    .temp_sensor_en, .irq);
  sops_host_model u_sops_host_model (.clk, .pins, .lvl);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("ERROR %0t no answer", $time);
    stop_test();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk);
      if (aw_r) aw_v <= 0;
      if (w_r) w_v <= 0;
      if (b_v) break;
    end
    if (k == 200) hang();
    chk(b_resp, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk);
      if (ar_r) ar_v <= 0;
      if (r_v) break;
    end
    if (k == 200) hang();
    chk(r_d, e);
    chk(r_resp, er);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(8);
    sys_rst <= 0;
    cyc(1);
    chk(pins.enable[1], 0);
    cyc(4);
    chk(pins.enable[0], 1);
    p = lvl[0];
    for (n = 0; n < 300 && lvl[0] === p; n++) @(posedge clk);
    p = lvl[0];
    for (n = 0; n < 300 && lvl[0] === p; n++) @(posedge clk);
    chk(32'(n), 32'(`SOPS_CLK_DIV / 2));
    rd(`SOPS_ADDR_CFG_A, 32'h3f, `SOPS_RESP_OKAY);
    rd(`SOPS_ADDR_CFG_B, 32'h2e, `SOPS_RESP_OKAY);
    rd(`SOPS_ADDR_CFG_C, 32'h00, `SOPS_RESP_OKAY);
    wr(8'h1c, 32'h1, `SOPS_RESP_SLVERR);
    rd(8'h1c, 32'h0, `SOPS_RESP_SLVERR);
    for (i = 0; i < 8; i++)
    begin
      wr(`SOPS_ADDR_CFG_C, 32'(i), `SOPS_RESP_OKAY);
      evt <= tbl[i][0];
      cyc(4);
      evt <= tbl[i][1];
      cyc(4);
      chk(lvl[2], 1);
      evt <= tbl[i][2];
      cyc(4);
      evt <= '0;
      cyc(4);
      chk(lvl[2], 0);
    end
    wr(`SOPS_ADDR_CFG_C, 32'h40, `SOPS_RESP_OKAY);
    cyc(4);
    chk(lvl[2], 1);
    wr(`SOPS_ADDR_IRQ_MASK, 32'h0, `SOPS_RESP_OKAY);
    cyc(3);
    chk(irq, 0);
    rd(`SOPS_ADDR_IRQ_STAT, 32'h3f, `SOPS_RESP_OKAY);
    wr(`SOPS_ADDR_IRQ_MASK, 32'h04, `SOPS_RESP_OKAY);
    cyc(3);
    chk(irq, 1);
    wr(`SOPS_ADDR_IRQ_STAT, 32'h3f, `SOPS_RESP_OKAY);
    cyc(3);
    chk(irq, 0);
    rd(`SOPS_ADDR_IRQ_STAT, 32'h0, `SOPS_RESP_OKAY);
    wr(`SOPS_ADDR_CFG_A, 32'h80, `SOPS_RESP_OKAY);
    cyc(3);
    chk(temp_sensor_en, 1);
    chk(pins.enable[0], 0);
    wr(`SOPS_ADDR_CFG_A, 32'h2e, `SOPS_RESP_OKAY);
    cyc(3);
    chk(temp_sensor_en, 0);
    chk(pins.enable[0], 0);
    serial_select_n <= 0;
    serial_data_out <= 1;
    cyc(6);
    chk(lvl[1], 1);
    serial_data_out <= 0;
    cyc(2);
    chk(lvl[1], 0);
    serial_select_n <= 1;
    cyc(6);
    chk(pins.enable[1], 0);
    wr(`SOPS_ADDR_CFG_B, 32'h02, `SOPS_RESP_OKAY);
    wr(`SOPS_ADDR_CFG_C, 32'h00, `SOPS_RESP_OKAY);
    evt <= 14'h2000;
    cyc(4);
    chk(lvl[1], 0);
    chk(lvl[2], 1);
    rd(`SOPS_ADDR_STATUS, 32'h4, `SOPS_RESP_OKAY);
    sleep_state <= 1;
    chip_ready_n <= 1;
    cyc(6);
    chk(lvl[1], 1);
    chk(lvl[2], 0);
    chk(pins.enable[0], 0);
    sleep_state <= 0;
    cyc(6);
    chk(lvl[1], 1);
    chk(lvl[2], 0);
    chip_ready_n <= 0;
    cyc(6);
    chk(lvl[1], 0);
    chk(lvl[2], 1);
    stop_test();
  end
endmodule // sops_status_pins_tb
`default_nettype wire
